// >>> hdl/fkm_pkg.sv
// Constants and types for the front keypad menu controller.
// Assumes a single 50 MHz clock and synchronous active-low reset.
package fkm_pkg;
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
	localparam int DEBOUNCE_MS = 20;
	localparam int DEBOUNCE_TICKS = DEBOUNCE_MS * 1000 / TICK_US;
	localparam int HOLD_S = 3;
	localparam int HOLD_TICKS = HOLD_S * 1_000_000 / TICK_US;
	localparam int IDLE_S = 10;
	localparam int IDLE_TICKS = IDLE_S * 1_000_000 / TICK_US;
	localparam int STEP_MS = 500;
	localparam int STEP_TICKS = STEP_MS * 1000 / TICK_US;
	localparam int TCNT_W = 14;

	// ---------------------------------------------------------------
	// Digits and keys
	// ---------------------------------------------------------------
	localparam int DIGITS = 6;
	localparam logic [3:0] DIGIT_MAX = 4'h9;
	localparam logic [3:0] DIGIT_MINUS = 4'hF;
	localparam int UNLOCK_LEN = 4;
	localparam logic [1:0] KEY_CONFIRM = 2'h0;
	localparam logic [1:0] KEY_ADJUST = 2'h1;
	localparam logic [1:0] KEY_COMMAND = 2'h2;
	localparam logic [7:0] UNLOCK_SEQ = 8'h12;

	// Operating states, Gray coded in listed order
	typedef enum logic [2:0] {
		FKM_NORMAL = 3'b000,
		FKM_LOCKED = 3'b001,
		FKM_BASIC = 3'b011,
		FKM_OPER = 3'b010,
		FKM_TEACH = 3'b110
	} fkm_state_t;
endpackage : fkm_pkg

// >>> hdl/fkm_key_if.sv
// Debounced key events shared between keypad modules.
// Assumes one clock domain; events are one-cycle pulses.
`timescale 1ns/1ps
interface fkm_key_if;
	logic [2:0] level;
	logic [2:0] press;
	logic [2:0] release_ev;
	logic tick;
	modport src (output level, output press, output release_ev, output tick);
	modport dst (input level, input press, input release_ev, input tick);
endinterface : fkm_key_if

// >>> hdl/fkm_debounce.sv
// Tick generator and key debouncer for three front keys.
// Assumes raw keys are active high and synchronous to the clock.
`timescale 1ns/1ps
module fkm_debounce #(
	parameter int TICK_CYCLES = fkm_pkg::TICK_CYCLES
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [2:0] key_raw,
	fkm_key_if.src keys
);
	logic [15:0] pre;
	logic [2:0] stable;

	// Free-running tick paces all timing
	always_ff @(posedge clock) begin
		if (!rst_n || pre == 16'(TICK_CYCLES - 1)) begin
			pre <= 16'h0000;
		end else begin
			pre <= pre + 16'h0001;
		end
	end
	assign keys.tick = (pre == 16'(TICK_CYCLES - 1));

	// One filter per key; a change must hold for the whole window
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_key
			logic [7:0] cnt;
			logic filt;
			// Own flop per key, so no vector bit has two writers
			assign stable[g] = filt;
			always_ff @(posedge clock) begin
				if (!rst_n) begin
					cnt <= 8'h00;
					filt <= 1'b0;
				end else if (key_raw[g] == filt) begin
					cnt <= 8'h00;
				end else if (keys.tick) begin
					if (cnt == 8'(fkm_pkg::DEBOUNCE_TICKS - 1)) begin
						filt <= key_raw[g];
						cnt <= 8'h00;
					end else begin
						cnt <= cnt + 8'h01;
					end
				end
			end
		end
	endgenerate

	// Edge pulses of debounced levels
	logic [2:0] prev;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			prev <= 3'b000;
		end else begin
			prev <= stable;
		end
	end
	assign keys.level = stable;
	assign keys.press = stable & ~prev;
	assign keys.release_ev = ~stable & prev;
endmodule : fkm_debounce

// >>> hdl/fkm_digits.sv
// Numeric entry editor: highlighted digit, scroll and wrap.
// Assumes load and step strobes are one-cycle pulses.
`timescale 1ns/1ps
module fkm_digits #(
	parameter int DIGITS = fkm_pkg::DIGITS
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [4*DIGITS-1:0] load_value,
	input wire logic is_signed,
	input wire logic step,
	input wire logic advance,
	output logic [4*DIGITS-1:0] value,
	output logic [$clog2(DIGITS)-1:0] cursor
);
	localparam int CW = $clog2(DIGITS);
	logic [3:0] cur;

	assign cur = value[4*cursor +: 4];

	// Digit update; top digit of signed values toggles 0 and minus
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			value <= '0;
			cursor <= '0;
		end else if (load) begin
			value <= load_value;
			cursor <= '0;
		end else if (step) begin
			if (is_signed && cursor == CW'(DIGITS - 1)) begin
				value[4*cursor +: 4] <= (cur == fkm_pkg::DIGIT_MINUS) ? 4'h0 : fkm_pkg::DIGIT_MINUS;
			end else begin
				value[4*cursor +: 4] <= (cur >= fkm_pkg::DIGIT_MAX) ? 4'h0 : cur + 4'h1;
			end
		end else if (advance) begin
			// Wrap to lowest digit so corrections stay possible
			cursor <= (cursor == CW'(DIGITS - 1)) ? '0 : cursor + CW'(1);
		end
	end
endmodule : fkm_digits

// >>> hdl/fkm_top.sv
// Front keypad menu controller: states, menu, entry, time-out, lock.
// Assumes keys arrive synchronous; parameter storage lives outside.
`timescale 1ns/1ps
module fkm_top #(
	parameter int DIGITS = fkm_pkg::DIGITS,
	parameter int ITEM_W = 6,
	parameter int POINT_W = 5,
	parameter int TICK_CYCLES = fkm_pkg::TICK_CYCLES
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [2:0] key_raw,
	input wire logic lock_enable,
	input wire logic item_signed,
	input wire logic [ITEM_W-1:0] item_last,
	input wire logic [4*DIGITS-1:0] stored_value,
	input wire logic [4*DIGITS-1:0] display_value,
	output fkm_pkg::fkm_state_t state,
	output logic [ITEM_W-1:0] item,
	output logic editing,
	output logic [4*DIGITS-1:0] edit_value,
	output logic [$clog2(DIGITS)-1:0] blink_digit,
	output logic lock_prompt,
	output logic commit,
	output logic [4*DIGITS-1:0] commit_value,
	output logic tare,
	output logic counter_reset,
	output logic teach_store,
	output logic [4*DIGITS-1:0] teach_value,
	output logic [POINT_W-1:0] teach_point,
	output logic restore_defaults
);
	// ---------------------------------------------------------------
	// Key events
	// ---------------------------------------------------------------
	fkm_key_if keys ();
	fkm_debounce #(.TICK_CYCLES(TICK_CYCLES)) u_deb (
		.clock(clock),
		.rst_n(rst_n),
		.key_raw(key_raw),
		.keys(keys)
	);

	logic c_lv;
	logic a_lv;
	logic m_lv;
	logic c_pr;
	logic a_pr;
	logic m_pr;
	logic a_rl;
	logic any_pr;
	assign c_lv = keys.level[fkm_pkg::KEY_CONFIRM];
	assign a_lv = keys.level[fkm_pkg::KEY_ADJUST];
	assign m_lv = keys.level[fkm_pkg::KEY_COMMAND];
	assign c_pr = keys.press[fkm_pkg::KEY_CONFIRM];
	assign a_pr = keys.press[fkm_pkg::KEY_ADJUST];
	assign m_pr = keys.press[fkm_pkg::KEY_COMMAND];
	assign a_rl = keys.release_ev[fkm_pkg::KEY_ADJUST];
	assign any_pr = |keys.press;

	// ---------------------------------------------------------------
	// Hold timing
	// ---------------------------------------------------------------
	// Hold counter restarts whenever the key combination changes
	logic [2:0] combo;
	logic [fkm_pkg::TCNT_W-1:0] hold;
	logic hold_done;
	logic hold_used;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			combo <= 3'b000;
			hold <= '0;
		end else if (keys.level != combo || keys.level == 3'b000) begin
			combo <= keys.level;
			hold <= '0;
		end else if (keys.tick && !hold_done) begin
			hold <= hold + fkm_pkg::TCNT_W'(1);
		end
	end
	assign hold_done = (hold == fkm_pkg::TCNT_W'(fkm_pkg::HOLD_TICKS));

	// One action per hold; cleared by releasing all keys
	logic fire;
	always_ff @(posedge clock) begin
		if (!rst_n || keys.level == 3'b000) begin
			hold_used <= 1'b0;
		end else if (hold_done) begin
			hold_used <= 1'b1;
		end
	end
	assign fire = hold_done && !hold_used;

	// ---------------------------------------------------------------
	// Inactivity timer
	// ---------------------------------------------------------------
	logic [fkm_pkg::TCNT_W-1:0] idle;
	logic idle_done;
	always_ff @(posedge clock) begin
		if (!rst_n || any_pr || keys.level != 3'b000 || state == fkm_pkg::FKM_NORMAL
		    || state == fkm_pkg::FKM_TEACH) begin
			idle <= '0;
		end else if (keys.tick && !idle_done) begin
			idle <= idle + fkm_pkg::TCNT_W'(1);
		end
	end
	assign idle_done = (idle == fkm_pkg::TCNT_W'(fkm_pkg::IDLE_TICKS));

	// ---------------------------------------------------------------
	// Power-up default restore
	// ---------------------------------------------------------------
	// Confirm must be seen held once debounce has settled after reset
	logic [7:0] boot;
	logic booted;
	assign booted = (boot == 8'(fkm_pkg::DEBOUNCE_TICKS + 2));
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			boot <= 8'h00;
			restore_defaults <= 1'b0;
		end else begin
			restore_defaults <= 1'b0;
			if (!booted && keys.tick) begin
				boot <= boot + 8'h01;
				if (boot == 8'(fkm_pkg::DEBOUNCE_TICKS + 1) && c_lv) begin
					restore_defaults <= 1'b1;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Unlock sequence
	// ---------------------------------------------------------------
	localparam int SEQ_W = $clog2(fkm_pkg::UNLOCK_LEN + 1);
	logic [SEQ_W-1:0] seq_pos;
	logic [1:0] pressed_id;
	logic [1:0] want_id;
	logic unlocked;
	assign pressed_id = c_pr ? fkm_pkg::KEY_CONFIRM : (a_pr ? fkm_pkg::KEY_ADJUST : fkm_pkg::KEY_COMMAND);
	assign want_id = fkm_pkg::UNLOCK_SEQ[2*seq_pos +: 2];
	always_ff @(posedge clock) begin
		if (!rst_n || state != fkm_pkg::FKM_LOCKED) begin
			seq_pos <= '0;
		end else if (any_pr) begin
			// Mismatch restarts, but a mismatching first key may begin anew
			if (pressed_id == want_id) begin
				seq_pos <= seq_pos + SEQ_W'(1);
			end else begin
				seq_pos <= (pressed_id == fkm_pkg::UNLOCK_SEQ[1:0]) ? SEQ_W'(1) : '0;
			end
		end
	end
	assign unlocked = (seq_pos == SEQ_W'(fkm_pkg::UNLOCK_LEN));

	// ---------------------------------------------------------------
	// Operating state
	// ---------------------------------------------------------------
	// Chosen entry is remembered while the unlock code is typed
	fkm_pkg::fkm_state_t pending;
	logic leave;
	assign leave = fire && combo == 3'b001;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state <= fkm_pkg::FKM_NORMAL;
			pending <= fkm_pkg::FKM_NORMAL;
		end else begin
			case (state)
				fkm_pkg::FKM_NORMAL: begin
					if (fire) begin
						// Only combinations below are recognised here
						if (combo == 3'b011) begin
							pending <= fkm_pkg::FKM_BASIC;
						end else if (combo == 3'b001) begin
							pending <= fkm_pkg::FKM_OPER;
						end else if (combo == 3'b010) begin
							pending <= fkm_pkg::FKM_TEACH;
						end
						if (combo == 3'b011 || combo == 3'b001 || combo == 3'b010) begin
							state <= lock_enable ? fkm_pkg::FKM_LOCKED : fkm_pkg::fkm_state_t'(
								combo == 3'b011 ? fkm_pkg::FKM_BASIC :
								combo == 3'b001 ? fkm_pkg::FKM_OPER : fkm_pkg::FKM_TEACH);
						end
					end
				end
				fkm_pkg::FKM_LOCKED: begin
					if (unlocked) begin
						state <= pending;
					end else if (idle_done) begin
						state <= fkm_pkg::FKM_NORMAL;
					end
				end
				fkm_pkg::FKM_BASIC, fkm_pkg::FKM_OPER: begin
					if (leave || idle_done) begin
						state <= fkm_pkg::FKM_NORMAL;
					end
				end
				fkm_pkg::FKM_TEACH: begin
					if (c_pr) begin
						state <= fkm_pkg::FKM_NORMAL;
					end
				end
				default: state <= fkm_pkg::FKM_NORMAL;
			endcase
		end
	end
	assign lock_prompt = (state == fkm_pkg::FKM_LOCKED);

	// ---------------------------------------------------------------
	// Menu item, editing and commit
	// ---------------------------------------------------------------
	logic in_setup;
	logic load;
	logic step;
	assign in_setup = (state == fkm_pkg::FKM_BASIC || state == fkm_pkg::FKM_OPER);

	// Scroll pace while adjust is held
	logic [9:0] step_cnt;
	always_ff @(posedge clock) begin
		if (!rst_n || !a_lv) begin
			step_cnt <= '0;
		end else if (keys.tick) begin
			step_cnt <= (step_cnt == 10'(fkm_pkg::STEP_TICKS - 1)) ? '0 : step_cnt + 10'h001;
		end
	end
	assign load = (in_setup || state == fkm_pkg::FKM_TEACH) && a_pr && !editing;
	assign step = editing && a_lv && keys.tick && step_cnt == '0;

	fkm_digits #(.DIGITS(DIGITS)) u_dig (
		.clock(clock),
		.rst_n(rst_n),
		.load(load),
		.load_value(state == fkm_pkg::FKM_TEACH ? display_value : stored_value),
		.is_signed(item_signed),
		.step(step),
		.advance(editing && a_rl),
		.value(edit_value),
		.cursor(blink_digit)
	);

	// Item pointer, edit flag and commit strobe
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			item <= '0;
			editing <= 1'b0;
			commit <= 1'b0;
			commit_value <= '0;
		end else begin
			commit <= 1'b0;
			if (!in_setup && state != fkm_pkg::FKM_TEACH) begin
				item <= '0;
				editing <= 1'b0;
			end else if (load) begin
				editing <= 1'b1;
			end else if (in_setup && c_pr && !m_lv) begin
				if (editing) begin
					commit <= 1'b1;
					commit_value <= edit_value;
					editing <= 1'b0;
				end
				item <= (item >= item_last) ? '0 : item + ITEM_W'(1);
			end
		end
	end

	// ---------------------------------------------------------------
	// Command key functions
	// ---------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			tare <= 1'b0;
			counter_reset <= 1'b0;
			teach_store <= 1'b0;
			teach_value <= '0;
			teach_point <= '0;
		end else begin
			tare <= m_pr && state == fkm_pkg::FKM_NORMAL && !c_lv;
			counter_reset <= m_pr && state == fkm_pkg::FKM_NORMAL && c_lv;
			teach_store <= 1'b0;
			if (state != fkm_pkg::FKM_TEACH) begin
				teach_point <= '0;
			end else if (m_pr) begin
				teach_store <= 1'b1;
				teach_value <= editing ? edit_value : display_value;
				teach_point <= teach_point + POINT_W'(1);
			end
		end
	end
endmodule : fkm_top

// >>> tb/fkm_operator.sv
// Operator model pressing the three front keys, with contact bounce.
// Assumes keys read high while pressed and low once released.
`timescale 1ns/1ps
module fkm_operator #(
	parameter int TICK_CYCLES = 2
) (
	input wire logic clock,
	output logic [2:0] key_raw
);
	// ---------------------------------------------------------------
	// Key presses
	// ---------------------------------------------------------------
	initial key_raw = 3'h0;
	// Bounce first so a press that chatters must still count once
	task automatic press(input logic [2:0] keys, input int ticks);
		repeat (3) begin
			@(negedge clock);
			key_raw = key_raw ^ keys;
		end
		@(negedge clock);
		key_raw = key_raw | keys;
		repeat (ticks * TICK_CYCLES) @(negedge clock);
		key_raw = key_raw & ~keys;
	endtask : press
endmodule : fkm_operator

// >>> tb/fkm_top_assertions.sv
// Concurrent checks on the keypad menu controller's ports.
// Assumes one clock domain; bound into every controller instance.
`timescale 1ns/1ps
module fkm_top_checker #(
	parameter int DIGITS = 6,
	parameter int ITEM_W = 6,
	parameter int TICK_CYCLES = 4
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [2:0] key_raw,
	input wire logic item_signed,
	input wire fkm_pkg::fkm_state_t state,
	input wire logic [ITEM_W-1:0] item,
	input wire logic editing,
	input wire logic [4*DIGITS-1:0] edit_value,
	input wire logic [$clog2(DIGITS)-1:0] blink_digit,
	input wire logic lock_prompt,
	input wire logic commit,
	input wire logic [4*DIGITS-1:0] commit_value,
	input wire logic tare,
	input wire logic counter_reset,
	input wire logic teach_store,
	input wire logic restore_defaults
);
	// ---------------------------------------------------------------
	// Helper counters and checks
	// ---------------------------------------------------------------
	localparam int IDLE_LIM = (fkm_pkg::IDLE_TICKS + 50) * TICK_CYCLES;
	localparam int HOLD_MIN = (fkm_pkg::HOLD_TICKS - 1) * TICK_CYCLES;
	int idle_cnt;
	int hold_cnt;
	logic [2:0] key_last;
	logic bad_digit;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Cycles with no key touched, saturating
	always_ff @(posedge clock) begin
		if (!rst_n || key_raw != 3'h0) idle_cnt <= 0;
		else if (idle_cnt < IDLE_LIM) idle_cnt <= idle_cnt + 1;
	end
	// Cycles of an unchanged key combination; debounce lag makes raw longer
	always_ff @(posedge clock) begin
		key_last <= key_raw;
		if (!rst_n || key_raw == 3'h0 || key_raw != key_last) hold_cnt <= 0;
		else if (hold_cnt < HOLD_MIN) hold_cnt <= hold_cnt + 1;
	end
	// Any non-decimal digit, the signed top minus excepted
	always_comb begin
		bad_digit = 1'b0;
		for (int i = 0; i < DIGITS; i++) begin
			if (edit_value[4*i +: 4] > fkm_pkg::DIGIT_MAX && !(i == DIGITS - 1 && item_signed
					&& edit_value[4*i +: 4] == fkm_pkg::DIGIT_MINUS)) bad_digit = 1'b1;
		end
	end
	chk_hold_entry_time: assert property (
		($past(state) == fkm_pkg::FKM_NORMAL && state != fkm_pkg::FKM_NORMAL) |-> hold_cnt >= HOLD_MIN)
		else $error("state left normal display without a full hold");
	chk_entry_from_normal: assert property (
		($changed(state) && state inside {fkm_pkg::FKM_BASIC, fkm_pkg::FKM_OPER, fkm_pkg::FKM_TEACH})
		|-> $past(state) inside {fkm_pkg::FKM_NORMAL, fkm_pkg::FKM_LOCKED})
		else $error("setup or teach entered from a wrong state");
	chk_command_normal: assert property (
		(tare || counter_reset) |-> state == fkm_pkg::FKM_NORMAL)
		else $error("tare or counter reset outside normal display");
	chk_commit_advance: assert property (
		commit |-> item != $past(item) && !editing)
		else $error("commit without menu advance");
	chk_commit_pulse: assert property (
		commit |=> !commit && commit_value == $past(commit_value))
		else $error("commit not a single pulse with held value");
	chk_edit_lowest: assert property (
		$rose(editing) |-> blink_digit == 0)
		else $error("entry did not start on the lowest digit");
	chk_digit_decimal: assert property (
		editing |-> !bad_digit)
		else $error("edited digit outside its range");
	chk_cursor_step: assert property (
		(editing && $past(editing) && $changed(blink_digit))
		|-> blink_digit == (($past(blink_digit) == DIGITS - 1) ? 0 : $past(blink_digit) + 1))
		else $error("highlight moved out of order");
	chk_idle_close: assert property (
		idle_cnt == IDLE_LIM |-> state inside {fkm_pkg::FKM_NORMAL, fkm_pkg::FKM_TEACH})
		else $error("menu stayed open after the idle time");
	chk_teach_no_timeout: assert property (
		($past(state) == fkm_pkg::FKM_TEACH && state != fkm_pkg::FKM_TEACH) |-> idle_cnt < 100 * TICK_CYCLES)
		else $error("teach closed without a key");
	chk_store_in_teach: assert property (
		teach_store |-> state == fkm_pkg::FKM_TEACH)
		else $error("teach point stored outside teach");
	chk_restore_once: assert property (
		restore_defaults |=> !restore_defaults [*8])
		else $error("restore defaults repeated");
	chk_lock_prompt: assert property (
		lock_prompt == (state == fkm_pkg::FKM_LOCKED))
		else $error("lock prompt does not follow locked state");
endmodule : fkm_top_checker
bind fkm_top fkm_top_checker #(.DIGITS(DIGITS), .ITEM_W(ITEM_W), .TICK_CYCLES(TICK_CYCLES)) fkm_top_checker_i (
	.clock(clock), .rst_n(rst_n), .key_raw(key_raw), .item_signed(item_signed), .state(state), .item(item),
	.editing(editing), .edit_value(edit_value), .blink_digit(blink_digit), .lock_prompt(lock_prompt),
	.commit(commit), .commit_value(commit_value), .tare(tare), .counter_reset(counter_reset),
	.teach_store(teach_store), .restore_defaults(restore_defaults));

// >>> tb/test_fkm_top.sv
// Self-checking bench for the keypad menu controller.
// Assumes the operator model drives the keys; a short tick keeps it quick.
`timescale 1ns/1ps
module test_fkm_top;
	// ---------------------------------------------------------------
	// Bench
	// ---------------------------------------------------------------
	localparam int TC = 2;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic lock_enable = 1'b0;
	logic item_signed = 1'b0;
	logic [2:0] key_raw;
	logic [23:0] stored_value = 24'h0;
	logic [23:0] display_value = 24'h0;
	logic [23:0] edit_value, commit_value, teach_value, exp_value;
	fkm_pkg::fkm_state_t state, last_state;
	logic [5:0] item;
	logic [2:0] blink_digit;
	logic [4:0] teach_point;
	logic editing, lock_prompt, commit, tare, counter_reset, teach_store, restore_defaults;
	logic [27:0] notes[$];
	int errors = 0;
	int checks_done = 0;
	int cycles = 0;
	int seed = 32'h73874707;
	// Menu wrap is left unchecked
	fkm_top #(.TICK_CYCLES(TC)) fkm_top_i (.clock(clock), .rst_n(rst_n), .key_raw(key_raw),
		.lock_enable(lock_enable), .item_signed(item_signed), .item_last(6'h05), .stored_value(stored_value),
		.display_value(display_value), .state(state), .item(item), .editing(editing), .edit_value(edit_value),
		.blink_digit(blink_digit), .lock_prompt(lock_prompt), .commit(commit), .commit_value(commit_value),
		.tare(tare), .counter_reset(counter_reset), .teach_store(teach_store), .teach_value(teach_value),
		.teach_point(teach_point), .restore_defaults(restore_defaults));
	fkm_operator #(.TICK_CYCLES(TC)) fkm_operator_i (.clock(clock), .key_raw(key_raw));
	initial begin
		forever #10 clock = ~clock;
	end
	task automatic check(input logic [27:0] seen, input logic [27:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic take(input logic [27:0] seen);
		if (notes.size() == 0) check(seen, 28'hFFFFFFF);
		else check(seen, notes.pop_front());
	endtask : take
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : give_verdict
	task automatic rest(input int ticks);
		repeat (ticks * TC) @(negedge clock);
	endtask : rest
	task automatic key(input logic [2:0] keys, input int ticks);
		fkm_operator_i.press(keys, ticks);
	endtask : key
	// Results in the order they appear, each against the oldest note
	always @(posedge clock) begin
		if (rst_n === 1'b1) begin
			if (state !== last_state) take({4'h1, 24'(state)});
			if (commit === 1'b1) take({4'h2, commit_value});
			if (tare === 1'b1) take({4'h3, 24'h0});
			if (counter_reset === 1'b1) take({4'h4, 24'h0});
			if (teach_store === 1'b1) take({4'h5, teach_value});
			if (restore_defaults === 1'b1) take({4'h6, 24'h0});
		end
		last_state <= state;
		cycles <= cycles + 1;
		// Scenarios need about 94k cycles; this leaves a small margin
		if (cycles == 99000) begin
			errors++;
			give_verdict();
		end
	end
	// Every digit is stepped once: plus one, and the signed top digit goes from zero to minus
	initial begin
		for (int i = 0; i < 5; i++) begin
			stored_value[4*i +: 4] = 4'(($random(seed) & 32'hFFFF) % 10);
			exp_value[4*i +: 4] = (stored_value[4*i +: 4] == 4'h9) ? 4'h0 : stored_value[4*i +: 4] + 4'h1;
		end
		stored_value[23:20] = 4'h0;
		exp_value[23:20] = fkm_pkg::DIGIT_MINUS;
		display_value = 24'($random(seed));
		notes.push_back({4'h6, 24'h0});
		fork
			key(3'h1, 60);
		join_none
		repeat (4) @(negedge clock);
		rst_n = 1'b1;
		rest(100);
		notes.push_back({4'h3, 24'h0});
		key(3'h4, 30);
		rest(30);
		notes.push_back({4'h4, 24'h0});
		fork
			key(3'h1, 80);
			begin
				rest(30);
				key(3'h4, 30);
			end
		join
		rest(30);
		$display("Test command keys done");
		notes.push_back({4'h1, 24'(fkm_pkg::FKM_OPER)});
		key(3'h1, 3100);
		rest(30);
		item_signed = 1'b1;
		repeat (6) begin
			key(3'h2, 30);
			rest(30);
		end
		check(28'(blink_digit), 28'h0);
		check(28'(editing), 28'h1);
		check(28'(edit_value), 28'(exp_value));
		notes.push_back({4'h2, exp_value});
		key(3'h1, 30);
		rest(30);
		check(28'(item), 28'h1);
		key(3'h2, 30);
		notes.push_back({4'h1, 24'(fkm_pkg::FKM_NORMAL)});
		rest(10100);
		check(28'(editing), 28'h0);
		$display("Test setup entry and time-out done");
		notes.push_back({4'h1, 24'(fkm_pkg::FKM_TEACH)});
		key(3'h2, 3100);
		rest(10100);
		check(28'(state), 28'(fkm_pkg::FKM_TEACH));
		notes.push_back({4'h5, display_value});
		key(3'h4, 30);
		rest(30);
		check(28'(teach_point), 28'h1);
		notes.push_back({4'h1, 24'(fkm_pkg::FKM_NORMAL)});
		key(3'h1, 30);
		rest(30);
		$display("Test teach done");
		// Locked basic entry, then the code typed from the package's key list
		lock_enable = 1'b1;
		notes.push_back({4'h1, 24'(fkm_pkg::FKM_LOCKED)});
		notes.push_back({4'h1, 24'(fkm_pkg::FKM_BASIC)});
		key(3'h3, 3100);
		rest(30);
		for (int i = 0; i < fkm_pkg::UNLOCK_LEN; i++) begin
			key(3'h1 << fkm_pkg::UNLOCK_SEQ[2*i +: 2], 30);
			rest(30);
		end
		notes.push_back({4'h1, 24'(fkm_pkg::FKM_NORMAL)});
		key(3'h1, 3100);
		rest(30);
		notes.push_back({4'h1, 24'(fkm_pkg::FKM_LOCKED)});
		key(3'h1, 3100);
		notes.push_back({4'h1, 24'(fkm_pkg::FKM_NORMAL)});
		rest(10100);
		$display("Test basic setup and lock done");
		check(28'(notes.size()), 28'h0);
		give_verdict();
	end
endmodule : test_fkm_top
